/* File: rtl/pvr_consts.svh */
// constants of the phy vendor control register bank
// Functional notes
// - bit 13 of register 17 enables energy-detect power-down; resets to zero
// - energy-present status drops to zero after 256 ms without line energy
// - energy-present is one after hardware reset, untouched by soft reset
// - register 18 holds mode in 7:5, address in 4:0, kept over soft reset
// - modes 000 and 001 give 10 Mb/s half and full, no autonegotiation
// - modes 010 and 011 give fixed 100 Mb/s; carrier on tx only in half
// - mode 100 autonegotiates advertising 100 half only; control 1101, adv 0100
// - mode 101 is repeater: autonegotiate, 100 half, carrier on receive only
// - mode 111 advertises all four; speed and duplex follow negotiated result
// - register 27 bit 15 picks strap or bits 14:13 for crossover; resets zero
// - override with bit 14 set enables automatic crossover; bit 13 kept zero
// - override, manual crossover: bit 13 zero straight pairs, one swaps them
// - register 27 bit 10 holds the 10M receive pll on reference; kept
// - register 27 bit 4 reports 10BASE-T receive polarity reversed
// - register 27 bits 3:0 are read-only and ignore writes
// - flags 7, 6, 5 latch energy, autonegotiation done, remote fault
// - flags 4 to 1 latch link down, ack, parallel fault, page; 0 reserved
// - link-down flag takes the line link state at reset
// - mask bits 7:0 of register 30 enable each source; reset to zero
`ifndef PVR_CONSTS_SVH
`define PVR_CONSTS_SVH

// register indices
`define PVR_IDX_EDPD 5'h11
`define PVR_IDX_SMODE 5'h12
`define PVR_IDX_XCTL 5'h1b
`define PVR_IDX_IRQSRC 5'h1d
`define PVR_IDX_IRQMASK 5'h1e

// field positions
`define PVR_EDPD_BIT 13
`define PVR_ENERGY_BIT 1
`define PVR_MODE_HI 7
`define PVR_MODE_LO 5
`define PVR_ADDR_HI 4
`define PVR_ADDR_LO 0
`define PVR_XOVR_BIT 15
`define PVR_XAUTO_BIT 14
`define PVR_XSTATE_BIT 13
`define PVR_PLL_BIT 10
`define PVR_POL_BIT 4
`define PVR_IRQ_LINK_BIT 4

// writable masks and reset values
`define PVR_EDPD_RW_MASK 16'hfffd
`define PVR_XCTL_RW_MASK 16'hfbe0
`define PVR_EDPD_RST 16'h0000
`define PVR_SMODE_RST 16'h00e1
`define PVR_XCTL_RST 16'h0000
`define PVR_PLL_RST 1'b0
`define PVR_MASK_RST 8'h00

// energy timeout
`define PVR_CLK_HZ 50000000
`define PVR_ENERGY_WINDOW_MS 256
`define PVR_ENERGY_CYCLES (`PVR_ENERGY_WINDOW_MS * (`PVR_CLK_HZ / 1000))

`endif

/* File: rtl/pvr_pkg.sv */
// types shared by the phy vendor control register bank
package pvr_pkg;
  typedef enum logic [2:0] {
    PVR_M_10HD = 3'h0,
    PVR_M_10FD = 3'h1,
    PVR_M_100HD = 3'h2,
    PVR_M_100FD = 3'h3,
    PVR_M_AN100HD = 3'h4,
    PVR_M_REPEATER = 3'h5,
    PVR_M_RSVD = 3'h6,
    PVR_M_ALLCAP = 3'h7
  } pvr_opmode_t;

  typedef struct packed {
    logic autoneg;
    logic speed100;
    logic full_duplex;
    logic crs_on_tx;
    logic repeater;
    logic [3:0] adv;
  } pvr_cfg_t;
endpackage

/* File: rtl/pvr_irq_if.sv */
// carrier between the register bank and its interrupt flag latch
`timescale 1ns/1ps
interface pvr_irq_if;
  logic [7:1] evt;
  logic rd_clear;
  logic link_init;
  logic [7:0] flags;
  modport ctrl (output evt, output rd_clear, output link_init, input flags);
  modport latch (input evt, input rd_clear, input link_init, output flags);
endinterface

/* File: rtl/pvr_energy_timer.sv */
// energy-present status with its silence timeout
`timescale 1ns/1ps
`include "pvr_consts.svh"
module pvr_energy_timer #(
  parameter int unsigned CYCLES = `PVR_ENERGY_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // line side
  input wire logic line_energy_valid,
  // status
  output logic energy_present,
  output logic energy_rise
);
  logic [23:0] silent_cnt;

  // count silent cycles; any energy restarts the window
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      silent_cnt <= 24'h000000;
    end else if (line_energy_valid) begin
      silent_cnt <= 24'h000000;
    end else if (silent_cnt != 24'(CYCLES - 1)) begin
      silent_cnt <= silent_cnt + 24'h000001;
    end
  end

  // status is one from hardware reset; soft reset never reaches here
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      energy_present <= 1'b1;
      energy_rise <= 1'b0;
    end else begin
      energy_rise <= line_energy_valid && !energy_present;
      if (line_energy_valid) begin
        energy_present <= 1'b1;
      end else if (silent_cnt == 24'(CYCLES - 1)) begin
        energy_present <= 1'b0;
      end
    end
  end

  a_energy_drop: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(energy_present) |-> $past(silent_cnt) == 24'(CYCLES - 1) && !$past(line_energy_valid))
    else $error("energy status fell before the silence window ran out");
endmodule // pvr_energy_timer

/* File: rtl/pvr_irq_latch.sv */
// sticky interrupt source flags, cleared by reading
`timescale 1ns/1ps
module pvr_irq_latch (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // flag carrier
  pvr_irq_if.latch bus
);
  logic init_pending;
  logic [7:0] set_vec;

  assign set_vec = {bus.evt, 1'b0};

  // first cycle after release loads link state into the link-down flag
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      init_pending <= 1'b1;
    end else begin
      init_pending <= 1'b0;
    end
  end

  // set wins over the read clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bus.flags <= 8'h00;
    end else if (init_pending) begin
      bus.flags <= set_vec | {3'h0, bus.link_init, 4'h0};
    end else if (bus.rd_clear) begin
      bus.flags <= set_vec;
    end else begin
      bus.flags <= bus.flags | set_vec;
    end
  end

  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (reset)
    bus.flags[6] && !bus.rd_clear |=> bus.flags[6])
    else $error("auto-negotiation flag dropped without a read");
  a_flag_readclr: assert property (@(posedge sys_clk) disable iff (reset)
    !init_pending && bus.rd_clear && !bus.evt[5] |=> !bus.flags[5])
    else $error("remote fault flag survived a read");
  a_flag_rsvd: assert property (@(posedge sys_clk) disable iff (reset)
    !bus.flags[0])
    else $error("reserved flag bit set");
endmodule // pvr_irq_latch

/* File: rtl/pvr_regs.sv */
// vendor management registers of the 10/100 phy
`timescale 1ns/1ps
`include "pvr_consts.svh"
module pvr_regs #(
  parameter int unsigned ENERGY_CYCLES = `PVR_ENERGY_CYCLES
) (
  // clock and resets
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic soft_reset,
  // management access by register index
  input wire logic [4:0] reg_index,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // line and negotiation status
  input wire logic line_energy_valid,
  input wire logic link_up,
  input wire logic autoneg_done_evt,
  input wire logic remote_fault_evt,
  input wire logic partner_ack_evt,
  input wire logic parallel_fault_evt,
  input wire logic page_received_evt,
  input wire logic crossover_auto_strap,
  input wire logic tenbase_polarity_reversed,
  input wire logic neg_speed100,
  input wire logic neg_full_duplex,
  // operating controls
  output logic energy_detect_powerdown_en,
  output pvr_pkg::pvr_opmode_t op_mode,
  output logic [4:0] phy_mgmt_addr,
  output logic autoneg_en,
  output logic ctrl_speed100,
  output logic ctrl_full_duplex,
  output logic [3:0] adv_abilities,
  output logic crs_on_tx,
  output logic repeater_mode,
  output logic crossover_auto_en,
  output logic crossover_swap,
  output logic rx_pll10_ref_lock,
  // status
  output logic energy_present,
  output logic phy_irq
);
  import pvr_pkg::*;

  logic [15:0] edpd_reg;
  logic [15:0] smode_reg;
  logic [15:0] xctl_reg;
  logic [7:0] irq_mask;
  logic [15:0] next_rdata;
  logic energy_rise;
  logic link_up_d;
  pvr_cfg_t cfg;
  pvr_opmode_t mode_now;

  pvr_irq_if irq_bus ();

  // true when this cycle writes the given index
  function automatic logic wr_hit(input logic [4:0] idx);
    wr_hit = reg_wr && (reg_index == idx);
  endfunction

  // mode table: controls and advertisement implied by each mode
  function automatic pvr_cfg_t mode_profile(input pvr_opmode_t m, input logic spd,
                                            input logic dup);
    pvr_cfg_t c;
    c = '0;
    unique case (m)
      PVR_M_10HD: begin
        c.full_duplex = 1'b0;
        c.crs_on_tx = 1'b1;
      end
      PVR_M_10FD: begin
        c.full_duplex = 1'b1;
      end
      PVR_M_100HD: begin
        c.speed100 = 1'b1;
        c.crs_on_tx = 1'b1;
      end
      PVR_M_100FD: begin
        c.speed100 = 1'b1;
        c.full_duplex = 1'b1;
      end
      PVR_M_AN100HD: begin
        c.autoneg = 1'b1;
        c.speed100 = 1'b1;
        c.crs_on_tx = 1'b1;
        c.adv = 4'h4;
      end
      PVR_M_REPEATER: begin
        c.autoneg = 1'b1;
        c.speed100 = 1'b1;
        c.repeater = 1'b1;
        c.adv = 4'h4;
      end
      PVR_M_ALLCAP: begin
        c.autoneg = 1'b1;
        c.speed100 = spd;
        c.full_duplex = dup;
        c.crs_on_tx = !dup;
        c.adv = 4'hf;
      end
      default: begin
        c.crs_on_tx = 1'b1; // reserved code: quiet 10 half, nothing advertised
      end
    endcase
    return c;
  endfunction

  // energy status and timeout
  pvr_energy_timer #(
    .CYCLES(ENERGY_CYCLES)
  ) u_energy (
    .sys_clk(sys_clk),
    .reset(reset),
    .line_energy_valid(line_energy_valid),
    .energy_present(energy_present),
    .energy_rise(energy_rise)
  );

  // interrupt source latch
  pvr_irq_latch u_irq (
    .sys_clk(sys_clk),
    .reset(reset),
    .bus(irq_bus.latch)
  );

  // link loss edge detector
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      link_up_d <= 1'b0;
    end else begin
      link_up_d <= link_up;
    end
  end

  // event vector into the flag latch
  assign irq_bus.evt = {energy_rise, autoneg_done_evt, remote_fault_evt,
                        link_up_d && !link_up, partner_ack_evt,
                        parallel_fault_evt, page_received_evt};
  assign irq_bus.rd_clear = reg_rd && (reg_index == `PVR_IDX_IRQSRC);
  assign irq_bus.link_init = !link_up;

  // register 17: power-down enable and reserved read/write bits
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      edpd_reg <= `PVR_EDPD_RST;
    end else if (soft_reset) begin
      edpd_reg <= `PVR_EDPD_RST;
    end else if (wr_hit(`PVR_IDX_EDPD)) begin
      edpd_reg <= reg_wdata & `PVR_EDPD_RW_MASK;
    end
  end

  assign energy_detect_powerdown_en = edpd_reg[`PVR_EDPD_BIT];

  // register 18: mode and address, kept over soft reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      smode_reg <= `PVR_SMODE_RST;
    end else if (wr_hit(`PVR_IDX_SMODE)) begin
      smode_reg <= reg_wdata;
    end
  end

  assign mode_now = pvr_opmode_t'(smode_reg[`PVR_MODE_HI:`PVR_MODE_LO]);
  assign phy_mgmt_addr = smode_reg[`PVR_ADDR_HI:`PVR_ADDR_LO];
  assign op_mode = mode_now;

  // register 27: crossover control, soft reset clears it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      xctl_reg <= `PVR_XCTL_RST;
    end else if (soft_reset) begin
      xctl_reg <= `PVR_XCTL_RST;
    end else if (wr_hit(`PVR_IDX_XCTL)) begin
      xctl_reg <= reg_wdata & `PVR_XCTL_RW_MASK;
    end
  end

  // register 27 bit 10: receive pll hold, kept over soft reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rx_pll10_ref_lock <= `PVR_PLL_RST;
    end else if (wr_hit(`PVR_IDX_XCTL)) begin
      rx_pll10_ref_lock <= reg_wdata[`PVR_PLL_BIT];
    end
  end

  // register 30: interrupt mask
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq_mask <= `PVR_MASK_RST;
    end else if (soft_reset) begin
      irq_mask <= `PVR_MASK_RST;
    end else if (wr_hit(`PVR_IDX_IRQMASK)) begin
      irq_mask <= reg_wdata[7:0];
    end
  end

  // masked interrupt request
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      phy_irq <= 1'b0;
    end else begin
      phy_irq <= |(irq_bus.flags & irq_mask);
    end
  end

  // crossover source and pair mapping
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      crossover_auto_en <= 1'b0;
      crossover_swap <= 1'b0;
    end else if (!xctl_reg[`PVR_XOVR_BIT]) begin
      crossover_auto_en <= crossover_auto_strap;
      crossover_swap <= 1'b0;
    end else begin
      crossover_auto_en <= xctl_reg[`PVR_XAUTO_BIT];
      // automatic detection wins if all three bits are written as one
      crossover_swap <= !xctl_reg[`PVR_XAUTO_BIT] && xctl_reg[`PVR_XSTATE_BIT];
    end
  end

  // operating controls decoded from the mode field
  assign cfg = mode_profile(mode_now, neg_speed100, neg_full_duplex);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      autoneg_en <= 1'b0;
      ctrl_speed100 <= 1'b0;
      ctrl_full_duplex <= 1'b0;
      adv_abilities <= 4'h0;
      crs_on_tx <= 1'b0;
      repeater_mode <= 1'b0;
    end else begin
      autoneg_en <= cfg.autoneg;
      ctrl_speed100 <= cfg.speed100;
      ctrl_full_duplex <= cfg.full_duplex;
      adv_abilities <= cfg.adv;
      crs_on_tx <= cfg.crs_on_tx;
      repeater_mode <= cfg.repeater;
    end
  end

  // read data mux; unmapped indices read zero
  always_comb begin
    next_rdata = 16'h0000;
    unique case (reg_index)
      `PVR_IDX_EDPD: begin
        next_rdata = edpd_reg;
        next_rdata[`PVR_ENERGY_BIT] = energy_present;
      end
      `PVR_IDX_SMODE: begin
        next_rdata = smode_reg;
      end
      `PVR_IDX_XCTL: begin
        next_rdata = xctl_reg;
        next_rdata[`PVR_PLL_BIT] = rx_pll10_ref_lock;
        next_rdata[`PVR_POL_BIT] = tenbase_polarity_reversed;
      end
      `PVR_IDX_IRQSRC: begin
        next_rdata = {8'h00, irq_bus.flags};
      end
      `PVR_IDX_IRQMASK: begin
        next_rdata = {8'h00, irq_mask};
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // read data is captured on the read strobe and held
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  a_edpd_write: assert property (@(posedge sys_clk) disable iff (reset)
    reg_wr && reg_index == `PVR_IDX_EDPD && !soft_reset
    |=> energy_detect_powerdown_en == $past(reg_wdata[13]))
    else $error("power-down enable did not follow the write");
  a_addr_kept: assert property (@(posedge sys_clk) disable iff (reset)
    soft_reset && !(reg_wr && reg_index == `PVR_IDX_SMODE) |=> $stable(phy_mgmt_addr))
    else $error("management address changed on soft reset");
  a_mode_fixed: assert property (@(posedge sys_clk) disable iff (reset)
    mode_now == PVR_M_100FD ##1 mode_now == PVR_M_100FD
    |-> !autoneg_en && ctrl_speed100 && ctrl_full_duplex && !crs_on_tx)
    else $error("fixed 100 full mode decoded wrongly");
  a_mode_an100: assert property (@(posedge sys_clk) disable iff (reset)
    mode_now == PVR_M_AN100HD |=> autoneg_en && adv_abilities == 4'h4 && crs_on_tx)
    else $error("autonegotiated 100 half mode decoded wrongly");
  a_mode_allcap: assert property (@(posedge sys_clk) disable iff (reset)
    mode_now == PVR_M_ALLCAP
    |=> adv_abilities == 4'hf && ctrl_speed100 == $past(neg_speed100))
    else $error("all-capable mode did not follow the negotiated speed");
  a_xover_strap: assert property (@(posedge sys_clk) disable iff (reset)
    !xctl_reg[15] |=> crossover_auto_en == $past(crossover_auto_strap) && !crossover_swap)
    else $error("strap did not steer crossover without override");
  a_xover_swap: assert property (@(posedge sys_clk) disable iff (reset)
    xctl_reg[15] && !xctl_reg[14] |=> crossover_swap == $past(xctl_reg[13]))
    else $error("manual crossover state not applied");
  a_pll_kept: assert property (@(posedge sys_clk) disable iff (reset)
    soft_reset && !reg_wr |=> $stable(rx_pll10_ref_lock))
    else $error("pll hold changed on soft reset");
  a_low_nibble: assert property (@(posedge sys_clk) disable iff (reset)
    reg_rd && reg_index == `PVR_IDX_XCTL |=> reg_rdata[3:0] == 4'h0)
    else $error("read-only low bits of register 27 changed");

  // mode table, status read-back and masking checks
  a_mode_10half: assert property (@(posedge sys_clk) disable iff (reset)
    mode_now == PVR_M_10HD
    |=> !autoneg_en && !ctrl_speed100 && !ctrl_full_duplex && crs_on_tx)
    else $error("10 half mode decoded wrongly");
  a_mode_10full: assert property (@(posedge sys_clk) disable iff (reset)
    mode_now == PVR_M_10FD
    |=> !autoneg_en && !ctrl_speed100 && ctrl_full_duplex && adv_abilities == 4'h0)
    else $error("10 full mode decoded wrongly");
  a_mode_100half: assert property (@(posedge sys_clk) disable iff (reset)
    mode_now == PVR_M_100HD
    |=> !autoneg_en && ctrl_speed100 && !ctrl_full_duplex && crs_on_tx)
    else $error("fixed 100 half mode decoded wrongly");
  a_mode_repeater: assert property (@(posedge sys_clk) disable iff (reset)
    mode_now == PVR_M_REPEATER
    |=> autoneg_en && repeater_mode && adv_abilities == 4'h4 && !crs_on_tx)
    else $error("repeater mode decoded wrongly");
  a_energy_read: assert property (@(posedge sys_clk) disable iff (reset)
    reg_rd && reg_index == `PVR_IDX_EDPD |=> reg_rdata[1] == $past(energy_present))
    else $error("energy status not seen in register 17");
  a_polarity_read: assert property (@(posedge sys_clk) disable iff (reset)
    reg_rd && reg_index == `PVR_IDX_XCTL
    |=> reg_rdata[4] == $past(tenbase_polarity_reversed))
    else $error("receive polarity not seen in register 27");
  a_link_flag: assert property (@(posedge sys_clk) disable iff (reset)
    link_up_d && !link_up |=> irq_bus.flags[`PVR_IRQ_LINK_BIT])
    else $error("link loss did not latch its flag");
  a_irq_masked: assert property (@(posedge sys_clk) disable iff (reset)
    irq_mask == 8'h00 |=> !phy_irq)
    else $error("interrupt raised with every source masked");
endmodule // pvr_regs

/* File: testbench/pvr_mgmt_master.sv */
// management master model that reaches the vendor registers by index
`timescale 1ns/1ps
module pvr_mgmt_master (
  // clock
  input wire logic sys_clk,
  // register access
  output logic [4:0] reg_index,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  // idle bus at time zero
  initial begin
    reg_index = 5'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end

  // one write, held across the taking edge; forbidden values are never sent
  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    logic bad;
    bad = (idx == 5'h12 && d[7:5] == 3'h6) || (idx == 5'h1b && d[15:13] == 3'h7);
    if (bad) begin
      $display("master skips a forbidden write");
    end else begin
      @(negedge sys_clk);
      reg_index = idx;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_wdata = ~d; // released data must not look valid
    end
  endtask

  // one read; data is taken once the registered answer has landed
  task automatic rd(input logic [4:0] idx, output logic [15:0] d);
    @(negedge sys_clk);
    reg_index = idx;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule // pvr_mgmt_master

/* File: testbench/pvr_regs_tb.sv */
// self-checking bench of the vendor register bank
`timescale 1ns/1ps
module pvr_regs_tb;
  import pvr_pkg::*;
  logic sys_clk, reset, soft_reset, reg_wr, reg_rd;
  logic [4:0] reg_index;
  logic [15:0] reg_wdata, reg_rdata;
  logic line_energy_valid, link_up, an_evt, rf_evt, ack_evt, pd_evt, pg_evt;
  logic strap, pol, neg_sp, neg_fd;
  logic edpd, an_en, sp100, fdx, crs, rep, x_auto, x_swap, pll_lock, energy, irq;
  pvr_opmode_t op_mode;
  logic [4:0] addr;
  logic [3:0] adv;
  int error_cnt, checked;
  logic [2:0] modes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  logic [8:0] m_exp [7] = '{9'h020, 9'h040, 9'h0a0, 9'h0c0, 9'h1a4, 9'h194, 9'h1cf};
  logic [8:0] m_msk [7] = '{9'h1f0, 9'h1f0, 9'h1f0, 9'h1f0, 9'h1ff, 9'h1ff, 9'h1df};
  logic [18:0] xo [6] = '{{1'b1, 16'h0000, 2'b10}, {1'b0, 16'h0000, 2'b00},
    {1'b1, 16'h2000, 2'b10}, {1'b0, 16'ha000, 2'b01}, {1'b0, 16'h8000, 2'b00},
    {1'b0, 16'hc000, 2'b10}};

  pvr_regs #(.ENERGY_CYCLES(16)) dut_u (.sys_clk(sys_clk), .reset(reset),
    .soft_reset(soft_reset), .reg_index(reg_index), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .line_energy_valid(line_energy_valid),
    .link_up(link_up), .autoneg_done_evt(an_evt), .remote_fault_evt(rf_evt),
    .partner_ack_evt(ack_evt), .parallel_fault_evt(pd_evt), .page_received_evt(pg_evt),
    .crossover_auto_strap(strap), .tenbase_polarity_reversed(pol), .neg_speed100(neg_sp),
    .neg_full_duplex(neg_fd), .energy_detect_powerdown_en(edpd), .op_mode(op_mode),
    .phy_mgmt_addr(addr), .autoneg_en(an_en), .ctrl_speed100(sp100),
    .ctrl_full_duplex(fdx), .adv_abilities(adv), .crs_on_tx(crs), .repeater_mode(rep),
    .crossover_auto_en(x_auto), .crossover_swap(x_swap), .rx_pll10_ref_lock(pll_lock),
    .energy_present(energy), .phy_irq(irq));

  pvr_mgmt_master mst_u (.sys_clk(sys_clk), .reg_index(reg_index), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // compare one value and count it
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // read a register and compare it
  task automatic rdc(input logic [4:0] idx, input logic [15:0] exp, input string what);
    logic [15:0] v;
    mst_u.rd(idx, v);
    check(what, v, exp);
  endtask

  // let a write reach the decoded outputs
  task automatic settle;
    repeat (2) @(negedge sys_clk);
  endtask

  // counts and verdict, then stop
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, well above the 170 or so cycles the tests need
  initial begin
    repeat (4000) @(posedge sys_clk);
    error_cnt++;
    give_verdict();
  end

  // main sequence
  initial begin
    {soft_reset, an_evt, rf_evt, ack_evt, pd_evt, pg_evt, strap, pol, neg_sp} = '0;
    {line_energy_valid, neg_fd, link_up, reset} = 4'b1101;
    error_cnt = 0;
    checked = 0;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    link_up = 1'b1;
    // reset values
    check("mode out", 16'(op_mode), 16'(PVR_M_ALLCAP));
    check("address out", 16'(addr), 16'h0001);
    check("adv out", {an_en, 11'h000, adv}, 16'h800f);
    rdc(5'h11, 16'h0002, "energy reg reset");
    rdc(5'h12, 16'h00e1, "mode reg reset");
    rdc(5'h1b, 16'h0000, "xover reg reset");
    rdc(5'h1d, 16'h0010, "flags reset");
    rdc(5'h1d, 16'h0000, "flags after read");
    $display("test reset values done");
    // writable bits, read-only bits and an unmapped index
    mst_u.wr(5'h11, 16'hfffd);
    rdc(5'h11, 16'hffff, "energy reg all");
    mst_u.wr(5'h11, 16'h0000);
    settle();
    check("powerdown off", 16'(edpd), 16'h0000);
    mst_u.wr(5'h11, 16'h2000);
    settle();
    check("powerdown on", 16'(edpd), 16'h0001);
    mst_u.wr(5'h05, 16'hffff);
    rdc(5'h05, 16'h0000, "unmapped");
    $display("test read write done");
    neg_sp = 1'b1; // negotiated 100 so the all-capable mode shows it
    // every legal operating mode
    for (int i = 0; i < 7; i++) begin
      mst_u.wr(5'h12, {8'h00, modes[i], 5'h03});
      settle();
      check("mode cfg", 16'({an_en, sp100, fdx, crs, rep, adv} & m_msk[i]),
        16'(m_exp[i] & m_msk[i]));
      check("address", 16'(addr), 16'h0003);
    end
    mst_u.wr(5'h12, 16'h00c3);
    $display("test modes done");
    // crossover source and pair mapping
    for (int i = 0; i < 6; i++) begin
      strap = xo[i][18];
      mst_u.wr(5'h1b, xo[i][17:2]);
      settle();
      check("xover", {14'h0000, x_auto, x_swap}, 16'(xo[i][1:0]));
    end
    mst_u.wr(5'h1b, 16'h800f);
    pol = 1'b1;
    rdc(5'h1b, 16'h8010, "polarity and ro bits");
    pol = 1'b0;
    $display("test crossover done");
    // soft reset keeps mode, address, pll lock and energy status
    mst_u.wr(5'h12, 16'h0085);
    mst_u.wr(5'h1b, 16'h8400);
    mst_u.wr(5'h1e, 16'h00ff);
    @(negedge sys_clk);
    soft_reset = 1'b1;
    @(negedge sys_clk);
    soft_reset = 1'b0;
    settle();
    check("pll lock kept", 16'(pll_lock), 16'h0001);
    rdc(5'h11, 16'h0002, "energy reg soft");
    rdc(5'h12, 16'h0085, "mode reg soft");
    rdc(5'h1b, 16'h0400, "xover reg soft");
    rdc(5'h1e, 16'h0000, "mask soft");
    $display("test soft reset done");
    // latched sources, one read clears them
    mst_u.wr(5'h1e, 16'h00ff);
    @(negedge sys_clk);
    {an_evt, rf_evt, ack_evt, pd_evt, pg_evt, link_up} = 6'b111110;
    @(negedge sys_clk);
    {an_evt, rf_evt, ack_evt, pd_evt, pg_evt, link_up} = 6'b000001;
    settle();
    check("irq raised", 16'(irq), 16'h0001);
    rdc(5'h1d, 16'h007e, "flags set");
    rdc(5'h1d, 16'h0000, "flags cleared");
    settle();
    check("irq low", 16'(irq), 16'h0000);
    $display("test flags done");
    // silence drops energy status only after the full window
    line_energy_valid = 1'b0;
    repeat (12) @(negedge sys_clk);
    check("energy held", 16'(energy), 16'h0001);
    repeat (8) @(negedge sys_clk);
    check("energy lost", 16'(energy), 16'h0000);
    rdc(5'h11, 16'h0000, "energy bit low");
    line_energy_valid = 1'b1;
    settle();
    rdc(5'h1d, 16'h0080, "energy flag");
    $display("test energy done");
    // masked source latches but keeps the line low
    mst_u.wr(5'h1e, 16'h0000);
    @(negedge sys_clk);
    pg_evt = 1'b1;
    @(negedge sys_clk);
    pg_evt = 1'b0;
    settle();
    check("irq masked", 16'(irq), 16'h0000);
    rdc(5'h1d, 16'h0002, "page flag");
    $display("test mask done");
    give_verdict();
  end
endmodule // pvr_regs_tb
